// >>> hw/ela_core.sv
module ela_core #(
  parameter int MON_W = 64,
  parameter int DEPTH = 1024,
  parameter int TRIG_W = 8,
  parameter int STIM_W = 8,
  parameter bit INIT_ARM = 1'b0,
  parameter logic [ela_pkg::TRIG_MAX-1:0] INIT_MASK = '0,
  parameter logic [ela_pkg::TRIG_MAX-1:0] INIT_VAL = '0,
  parameter logic [ela_pkg::TRIG_MAX-1:0] INIT_EDGE = '0,
  parameter bit INIT_OR = 1'b0,
  parameter logic [1:0] INIT_PRE = 2'h0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic core_ce,
  input wire logic [MON_W-1:0] mon_data,
  input wire logic [TRIG_W-1:0] trig_in,
  output logic [(STIM_W > 0 ? STIM_W : 1)-1:0] stimuli,
  output logic capture_done,
  output logic capture_armed,
  input wire logic jtag_tck,
  input wire logic jtag_sel,
  input wire logic jtag_capture,
  input wire logic jtag_shift,
  input wire logic jtag_update,
  input wire logic jtag_tdi,
  input wire logic user_tdo,
  output logic jtag_tdo,
  output logic jtag_tdo_en
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = STIM_W > 0 ? STIM_W : 1;
  localparam int NCH = (MON_W + ela_pkg::WORD_W - 1) / ela_pkg::WORD_W;
  if (MON_W < 1 || MON_W > ela_pkg::MON_MAX || TRIG_W < 1 || TRIG_W > ela_pkg::TRIG_MAX ||
      STIM_W < 0 || STIM_W > ela_pkg::STIM_MAX || DEPTH < ela_pkg::DEPTH_MIN || DEPTH > ela_pkg::DEPTH_MAX ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_param
    $error("parameter out of range or depth not a power of two");
  end
  typedef enum logic [2:0] {ELA_IDLE, ELA_PRE, ELA_TRIG, ELA_POST, ELA_DONE} ela_state_e;
  function automatic logic ela_cond_hit(input ela_pkg::ela_cond_s c, input logic [TRIG_W-1:0] t,
                                        input logic [TRIG_W-1:0] p);
    logic [TRIG_W-1:0] hit;
    hit = '0;
    for (int i = 0; i < TRIG_W; i++) begin
      if (!c.edge_sel[i]) begin
        hit[i] = t[i] == c.val[i];
      end else if (c.val[i]) begin
        hit[i] = t[i] & ~p[i];
      end else begin
        hit[i] = ~t[i] & p[i];
      end
    end
    return c.use_or ? |(hit & c.mask[TRIG_W-1:0]) : &(hit | ~c.mask[TRIG_W-1:0]);
  endfunction
  function automatic logic [AW:0] ela_pre_len(input logic [1:0] q);
    return (AW + 1)'(q) * (AW + 1)'(DEPTH / ela_pkg::QUARTERS);
  endfunction

  // ---------------- JTAG clock domain ----------------
  logic [ela_pkg::FRAME_W-1:0] sr_q;
  ela_pkg::ela_cond_s jcond_q [ela_pkg::COND_N];
  ela_pkg::ela_ctrl_s jctrl_q;
  logic [SW-1:0] jstim_q;
  logic [ela_pkg::SEL_W-1:0] jrd_sel_q;
  logic arm_tgl_q, next_tgl_q, rd_tgl_q, rd_pend_q;
  logic ack_s1_q, ack_s2_q, ack_seen_q;
  logic done_s1_q, done_s2_q, armed_s1_q, armed_s2_q;
  logic [ela_pkg::CNT_W+ela_pkg::WORD_W-1:0] resp_q;
  logic ack_tgl_q;
  logic upd;
  logic [ela_pkg::OP_W-1:0] op;
  logic [ela_pkg::SEL_W-1:0] sel;
  logic [ela_pkg::WORD_W-1:0] wdata;
  logic [ela_pkg::STAT_W-1:0] stat;
  assign upd = jtag_sel & jtag_update;
  assign op = sr_q[ela_pkg::FRAME_W-1 -: ela_pkg::OP_W];
  assign sel = sr_q[ela_pkg::WORD_W +: ela_pkg::SEL_W];
  assign wdata = sr_q[ela_pkg::WORD_W-1:0];
  always_comb begin
    stat = '0;
    stat[ela_pkg::ST_READY_BIT] = ~rd_pend_q;
    stat[ela_pkg::ST_DONE_BIT] = done_s2_q;
    stat[ela_pkg::ST_ARMED_BIT] = armed_s2_q;
  end

  always_ff @(posedge jtag_tck or negedge rst_b) begin
    if (!rst_b) begin
      sr_q <= '0;
    end else if (jtag_sel && jtag_capture) begin
      sr_q <= {stat, resp_q};
    end else if (jtag_sel && jtag_shift) begin
      sr_q <= {jtag_tdi, sr_q[ela_pkg::FRAME_W-1:1]};
    end
  end

  assign jtag_tdo = jtag_sel ? sr_q[0] : user_tdo;
  assign jtag_tdo_en = jtag_shift;

  always_ff @(posedge jtag_tck or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < ela_pkg::COND_N; c++) begin
        jcond_q[c] <= '0;
      end
      jctrl_q <= '0;
    end else if (upd && op == ela_pkg::ELA_OP_TRIG) begin
      unique case (ela_pkg::ela_fld_e'(sel[ela_pkg::SEL_FLD_LSB +: 2]))
        ela_pkg::ELA_FLD_MASK: jcond_q[sel[ela_pkg::SEL_COND_LSB +: 2]].mask <= wdata[ela_pkg::TRIG_MAX-1:0];
        ela_pkg::ELA_FLD_VAL: jcond_q[sel[ela_pkg::SEL_COND_LSB +: 2]].val <= wdata[ela_pkg::TRIG_MAX-1:0];
        ela_pkg::ELA_FLD_EDGE: jcond_q[sel[ela_pkg::SEL_COND_LSB +: 2]].edge_sel <= wdata[ela_pkg::TRIG_MAX-1:0];
        ela_pkg::ELA_FLD_COMB: jcond_q[sel[ela_pkg::SEL_COND_LSB +: 2]].use_or <= wdata[0];
      endcase
    end else if (upd && op == ela_pkg::ELA_OP_CTRL) begin
      jctrl_q.pre_qtr <= wdata[ela_pkg::CTRL_PRE_LSB +: 2];
      jctrl_q.rpt <= wdata[ela_pkg::CTRL_RPT_BIT];
      jctrl_q.last_cond <= wdata[ela_pkg::CTRL_LAST_LSB +: 2];
    end
  end

  always_ff @(posedge jtag_tck or negedge rst_b) begin
    if (!rst_b) begin
      jstim_q <= '0;
    end else if (upd && op == ela_pkg::ELA_OP_STIM) begin
      for (int i = 0; i < SW; i++) begin
        if (i / ela_pkg::WORD_W == int'(sel[ela_pkg::CHUNK_W-1:0])) begin
          jstim_q[i] <= wdata[i % ela_pkg::WORD_W];
        end
      end
    end
  end

  // command toggles and read handshake toward the user clock
  always_ff @(posedge jtag_tck or negedge rst_b) begin
    if (!rst_b) begin
      arm_tgl_q <= 1'b0;
      next_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
      rd_pend_q <= 1'b0;
      jrd_sel_q <= '0;
      ack_seen_q <= 1'b0;
    end else begin
      ack_seen_q <= ack_s2_q;
      if (ack_s2_q != ack_seen_q) begin
        rd_pend_q <= 1'b0;
      end
      arm_tgl_q <= arm_tgl_q ^ (upd && op == ela_pkg::ELA_OP_ARM);
      next_tgl_q <= next_tgl_q ^ (upd && op == ela_pkg::ELA_OP_NEXT);
      if (upd && op == ela_pkg::ELA_OP_READ && !rd_pend_q) begin
        rd_tgl_q <= ~rd_tgl_q;
        rd_pend_q <= 1'b1;
        jrd_sel_q <= sel;
      end
    end
  end

  // status back into the JTAG clock
  always_ff @(posedge jtag_tck or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      armed_s1_q <= 1'b0;
      armed_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      done_s1_q <= capture_done;
      done_s2_q <= done_s1_q;
      armed_s1_q <= capture_armed;
      armed_s2_q <= armed_s1_q;
    end
  end

  // ---------------- User clock domain ----------------
  logic [2:0] arm_s_q, next_s_q, rd_s_q;
  logic arm_p, next_p, rd_p;
  ela_pkg::ela_cond_s ccond_q [ela_pkg::COND_N];
  ela_pkg::ela_ctrl_s cctrl_q;
  logic [SW-1:0] stim_q;
  ela_state_e st_q;
  logic [AW-1:0] wr_ptr_q, start_q;
  logic [AW:0] cnt_q;
  logic [1:0] stage_q;
  logic [ela_pkg::CNT_W-1:0] cap_cnt_q;
  logic [TRIG_W-1:0] trig_prev_q;
  logic [MON_W-1:0] mem [DEPTH];
  logic [MON_W-1:0] rword_q;
  logic rd_stage_q;
  logic [ela_pkg::CHUNK_W-1:0] rchunk_q;
  logic [NCH*ela_pkg::WORD_W-1:0] rpad;
  logic capturing, hit;
  logic [AW:0] pre_len, post_len;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_s_q <= '0;
      next_s_q <= '0;
      rd_s_q <= '0;
    end else if (core_ce) begin
      arm_s_q <= {arm_s_q[1:0], arm_tgl_q};
      next_s_q <= {next_s_q[1:0], next_tgl_q};
      rd_s_q <= {rd_s_q[1:0], rd_tgl_q};
    end
  end
  assign arm_p = arm_s_q[2] ^ arm_s_q[1];
  assign next_p = next_s_q[2] ^ next_s_q[1];
  assign rd_p = rd_s_q[2] ^ rd_s_q[1];
  // initial condition out of reset; settings taken at arm
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < ela_pkg::COND_N; c++) begin
        ccond_q[c] <= '0;
      end
      ccond_q[0] <= '{use_or: INIT_OR, mask: INIT_MASK, val: INIT_VAL, edge_sel: INIT_EDGE};
      cctrl_q <= '{pre_qtr: INIT_PRE, rpt: 1'b0, last_cond: 2'h0};
      stim_q <= '0;
    end else if (core_ce && arm_p) begin
      ccond_q <= jcond_q;
      cctrl_q <= jctrl_q;
      stim_q <= jstim_q;
    end
  end
  assign stimuli = STIM_W > 0 ? stim_q : '0;
  assign pre_len = ela_pre_len(cctrl_q.pre_qtr);
  assign post_len = (AW + 1)'(DEPTH) - pre_len;
  assign capturing = st_q == ELA_PRE || st_q == ELA_TRIG || st_q == ELA_POST;
  assign hit = ela_cond_hit(ccond_q[stage_q], trig_in, trig_prev_q);
  assign capture_done = st_q == ELA_DONE;
  assign capture_armed = capturing;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_prev_q <= '0;
    end else if (core_ce) begin
      trig_prev_q <= trig_in;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= INIT_ARM ? (INIT_PRE == 2'h0 ? ELA_TRIG : ELA_PRE) : ELA_IDLE;
      wr_ptr_q <= '0;
      start_q <= '0;
      cnt_q <= '0;
      stage_q <= '0;
      cap_cnt_q <= '0;
    end else if (core_ce) begin
      if (capturing) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (arm_p || (st_q == ELA_DONE && next_p && cctrl_q.rpt)) begin
        st_q <= ela_pre_len(arm_p ? jctrl_q.pre_qtr : cctrl_q.pre_qtr) == '0 ? ELA_TRIG : ELA_PRE;
        cnt_q <= '0;
        stage_q <= '0;
      end else begin
        unique case (st_q)
          ELA_IDLE, ELA_DONE: begin
          end
          ELA_PRE: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q + 1'b1 >= pre_len) begin
              st_q <= ELA_TRIG;
            end
          end
          ELA_TRIG: begin
            if (hit && stage_q >= cctrl_q.last_cond) begin
              st_q <= ELA_POST;
              cnt_q <= (AW + 1)'(1);
            end else if (hit) begin
              stage_q <= stage_q + 1'b1;
            end
          end
          // fill the remaining depth then stop
          ELA_POST: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == post_len - 1'b1) begin
              st_q <= ELA_DONE;
              start_q <= wr_ptr_q + 1'b1;
              cap_cnt_q <= cap_cnt_q + 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (core_ce && capturing) begin
      mem[wr_ptr_q] <= mon_data;
    end
    if (core_ce && rd_p) begin
      rword_q <= mem[start_q + jrd_sel_q[AW-1:0]];
    end
  end

  assign rpad = (NCH * ela_pkg::WORD_W)'(rword_q);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_stage_q <= 1'b0;
      rchunk_q <= '0;
      resp_q <= '0;
      ack_tgl_q <= 1'b0;
    end else if (core_ce) begin
      rd_stage_q <= rd_p;
      if (rd_p) begin
        rchunk_q <= jrd_sel_q[ela_pkg::RD_CHUNK_LSB +: ela_pkg::CHUNK_W];
      end
      if (rd_stage_q) begin
        resp_q <= {cap_cnt_q, int'(rchunk_q) < NCH ? rpad[rchunk_q * ela_pkg::WORD_W +: ela_pkg::WORD_W] :
                   {ela_pkg::WORD_W{1'b0}}};
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  chk_samp_advance: assert property (core_ce && capturing |=> wr_ptr_q == $past(wr_ptr_q) + 1'b1)
    else $error("write pointer did not advance while capturing");
  chk_pre_fill: assert property (core_ce && !arm_p && st_q == ELA_PRE && cnt_q + 1'b1 >= pre_len |=> st_q == ELA_TRIG)
    else $error("pre-trigger fill did not end at its length");
  chk_stage_order: assert property (core_ce && !arm_p && st_q == ELA_TRIG && !hit |=> $stable(stage_q))
    else $error("trigger stage moved without a hit");
  chk_last_fire: assert property (core_ce && !arm_p && st_q == ELA_TRIG && hit && stage_q >= cctrl_q.last_cond
    |=> st_q == ELA_POST && cnt_q == 1)
    else $error("final condition hit did not start post capture");
  chk_post_stop: assert property (core_ce && !arm_p && st_q == ELA_POST && cnt_q == post_len - 1'b1
    |=> capture_done && !capture_armed && start_q == wr_ptr_q)
    else $error("capture did not stop after the post length");
  chk_rpt_rearm: assert property (core_ce && st_q == ELA_DONE && next_p && cctrl_q.rpt |=> capture_armed)
    else $error("repeat mode did not re-arm");
  chk_stim_before: assert property (core_ce && arm_p |=> stimuli == $past(STIM_W > 0 ? jstim_q : '0) && capture_armed)
    else $error("stimuli not presented at arm");
  chk_read_ack: assert property (core_ce && rd_p ##1 core_ce |=> $changed(ack_tgl_q))
    else $error("read answer not returned two cycles after request");
  chk_tdo_share: assert property (@(posedge jtag_tck) disable iff (!rst_b) !jtag_sel |-> jtag_tdo == user_tdo)
    else $error("scan output not handed to user logic");
  chk_done_cross: assert property (@(posedge jtag_tck) disable iff (!rst_b) done_s1_q |=> done_s2_q)
    else $error("done status not carried across");
  cov_capture_done: cover property (st_q == ELA_POST ##1 st_q == ELA_DONE);
  cov_three_stage: cover property (st_q == ELA_TRIG && stage_q == 2'h2 && hit);
  cov_repeat: cover property (st_q == ELA_DONE && next_p && cctrl_q.rpt);
  cov_read: cover property (rd_stage_q);
endmodule

// >>> hw/ela_pkg.sv
package ela_pkg;
  localparam int TRIG_MAX = 40;
  localparam int MON_MAX = 4064;
  localparam int STIM_MAX = 512;
  localparam int DEPTH_MIN = 512;
  localparam int DEPTH_MAX = 16384;
  localparam int COND_N = 3;
  localparam int QUARTERS = 4;

  // Host frame: {opcode, selector, data word}, shifted LSB first
  localparam int WORD_W = 64;
  localparam int OP_W = 4;
  localparam int SEL_W = 24;
  localparam int STAT_W = 4;
  localparam int FRAME_W = OP_W + SEL_W + WORD_W;
  localparam int CHUNK_W = 6;
  localparam int CNT_W = 24;

  // Selector fields
  localparam int SEL_COND_LSB = 0;
  localparam int SEL_FLD_LSB = 2;
  localparam int RD_CHUNK_LSB = 18;

  // Control word fields
  localparam int CTRL_PRE_LSB = 0;
  localparam int CTRL_RPT_BIT = 2;
  localparam int CTRL_LAST_LSB = 3;

  // Status bits returned on capture
  localparam int ST_READY_BIT = 3;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_ARMED_BIT = 1;

  typedef enum logic [3:0] {
    ELA_OP_NOP = 4'h0,
    ELA_OP_TRIG = 4'h1,
    ELA_OP_STIM = 4'h2,
    ELA_OP_CTRL = 4'h3,
    ELA_OP_ARM = 4'h4,
    ELA_OP_READ = 4'h5,
    ELA_OP_NEXT = 4'h6
  } ela_op_e;

  typedef enum logic [1:0] {
    ELA_FLD_MASK = 2'h0,
    ELA_FLD_VAL = 2'h1,
    ELA_FLD_EDGE = 2'h2,
    ELA_FLD_COMB = 2'h3
  } ela_fld_e;

  typedef struct packed {
    logic use_or;
    logic [TRIG_MAX-1:0] mask;
    logic [TRIG_MAX-1:0] val;
    logic [TRIG_MAX-1:0] edge_sel;
  } ela_cond_s;

  typedef struct packed {
    logic [1:0] pre_qtr;
    logic rpt;
    logic [1:0] last_cond;
  } ela_ctrl_s;
endpackage

// >>> verif/ela_core_tb.sv
module ela_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MON_W = 16;
  localparam int DEPTH = 512;
  localparam int TRIG_W = 4;
  localparam logic [1:0] INIT_PRE = 2'h1;
  localparam int PRE_LEN = DEPTH / 4 * INIT_PRE;
  typedef struct packed {logic [23:0] sel; logic [63:0] mask; logic [63:0] exp;} ela_rd_row_s;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic core_ce = 1'b1;
  logic user_tdo = 1'b0;
  logic [TRIG_W-1:0] trig_in = 4'h0;
  logic [11:0] cnt = 12'h000;
  logic [MON_W-1:0] mon_data;
  logic [7:0] stimuli;
  logic capture_done, capture_armed, jtag_tck, jtag_sel, jtag_capture, jtag_shift, jtag_update;
  logic jtag_tdi, jtag_tdo, jtag_tdo_en, en_bad;
  logic [91:0] resp;
  logic [63:0] d;
  logic [11:0] cnts [5];
  logic [63:0] cfg [3][4];
  logic [3:0] seq [4];
  ela_rd_row_s rows [5];
  int err_count = 0;
  int n_tests = 0;

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cnt <= #2 cnt + 12'h001;
  assign mon_data = {cnt, trig_in};

  ela_core #(.MON_W(MON_W), .DEPTH(DEPTH), .TRIG_W(TRIG_W), .INIT_ARM(1'b1), .INIT_MASK(40'h1), .INIT_VAL(40'h1),
    .INIT_EDGE(40'h1), .INIT_PRE(INIT_PRE)) i_ela_core (
    .core_clk(core_clk), .rst_b(rst_b), .core_ce(core_ce), .mon_data(mon_data), .trig_in(trig_in),
    .stimuli(stimuli), .capture_done(capture_done), .capture_armed(capture_armed), .jtag_tck(jtag_tck),
    .jtag_sel(jtag_sel), .jtag_capture(jtag_capture), .jtag_shift(jtag_shift), .jtag_update(jtag_update),
    .jtag_tdi(jtag_tdi), .user_tdo(user_tdo), .jtag_tdo(jtag_tdo), .jtag_tdo_en(jtag_tdo_en));

  ela_host i_ela_host (
    .jtag_tck(jtag_tck), .jtag_sel(jtag_sel), .jtag_capture(jtag_capture), .jtag_shift(jtag_shift),
    .jtag_update(jtag_update), .jtag_tdi(jtag_tdi), .en_bad(en_bad), .jtag_tdo(jtag_tdo),
    .jtag_tdo_en(jtag_tdo_en));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] op, input logic [23:0] sel, input logic [63:0] dat);
    i_ela_host.frame(op, sel, dat, resp);
  endtask

  // Read request, then a second frame to collect the answer
  task automatic rd(input logic [23:0] sel, output logic [63:0] q);
    wr(ela_pkg::ELA_OP_READ, sel, 64'h0);
    wr(ela_pkg::ELA_OP_NOP, 24'h0, 64'h0);
    chk(64'(resp[88+ela_pkg::ST_READY_BIT]), 64'h1);
    q = resp[63:0];
  endtask

  task automatic wait_core(input bit want_done, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge core_clk);
      #2;
      if ((want_done ? capture_done : capture_armed) === 1'b1) break;
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    rows = '{'{24'd127, 64'h1, 64'h0}, '{24'd128, 64'h1, 64'h1}, '{24'h040080, 64'hffff, 64'h0},
             '{24'd129, 64'h1, 64'h1}, '{24'd511, 64'h1, 64'h1}};
    cfg = '{'{64'h2, 64'h2, 64'h0, 64'h0}, '{64'hc, 64'hc, 64'h0, 64'h1}, '{64'h1, 64'h0, 64'h1, 64'h0}};
    seq = '{4'h0, 4'h2, 4'hb, 4'ha};
    fork
      repeat (10) @(posedge core_clk);
      i_ela_host.idle(4);
    join
    chk(64'(stimuli), 64'h0);
    chk(64'(capture_done), 64'h0);
    chk(64'(capture_armed), 64'h1);
    #2 rst_b = 1'b1;
    for (int b = 0; b < 2; b++) begin
      @(posedge core_clk);
      #2 user_tdo = b[0];
      #1 chk(64'(jtag_tdo), 64'(b[0]));
    end
    $display("test reset done");

    repeat (300) @(posedge core_clk);
    #2 trig_in = 4'h1;
    wait_core(1'b1, 1000);
    chk(64'(capture_done), 64'h1);
    foreach (rows[i]) begin
      rd(rows[i].sel, d);
      chk(d & rows[i].mask, rows[i].exp);
      cnts[i] = d[15:4];
    end
    chk(64'(12'(cnts[3] - cnts[1])), 64'h1);
    chk(64'(12'(cnts[4] - cnts[1])), 64'(DEPTH - PRE_LEN - 1));
    chk(64'(resp[87:64]), 64'h1);
    $display("test initial trigger done");

    for (int c = 0; c < 3; c++) begin
      for (int f = 0; f < 4; f++) begin
        wr(ela_pkg::ELA_OP_TRIG, 24'((f << ela_pkg::SEL_FLD_LSB) | c), cfg[c][f]);
      end
    end
    wr(ela_pkg::ELA_OP_STIM, 24'h0, 64'ha5);
    wr(ela_pkg::ELA_OP_CTRL, 24'h0, 64'h14);
    chk(64'(stimuli), 64'h0);
    wr(ela_pkg::ELA_OP_ARM, 24'h0, 64'h0);
    wait_core(1'b0, 100);
    chk(64'(capture_armed), 64'h1);
    chk(64'(stimuli), 64'ha5);
    foreach (seq[i]) begin
      repeat (5) @(posedge core_clk);
      #2 trig_in = seq[i];
    end
    wait_core(1'b1, 1000);
    chk(64'(capture_done), 64'h1);
    rd(24'h0, d);
    chk(d & 64'hf, 64'ha);
    chk(64'(resp[87:64]), 64'h2);
    $display("test sequential trigger done");

    wr(ela_pkg::ELA_OP_NEXT, 24'h0, 64'h0);
    wait_core(1'b0, 200);
    chk(64'(capture_armed), 64'h1);
    repeat (5) @(posedge core_clk);
    #2 trig_in = 4'hb;
    repeat (5) @(posedge core_clk);
    #2 trig_in = 4'ha;
    wait_core(1'b1, 1000);
    chk(64'(capture_done), 64'h1);
    rd(24'h0, d);
    chk(d & 64'hf, 64'ha);
    chk(64'(resp[87:64]), 64'h3);
    chk(64'(resp[88+ela_pkg::ST_DONE_BIT]), 64'h1);
    chk(64'(stimuli), 64'ha5);
    chk(64'(en_bad), 64'h0);
    $display("test repeat mode done");

    // Clock enable low freezes the re-arm until it returns
    @(posedge core_clk);
    #2 core_ce = 1'b0;
    wr(ela_pkg::ELA_OP_NEXT, 24'h0, 64'h0);
    chk(64'({capture_done, capture_armed}), 64'h2);
    @(posedge core_clk);
    #2 core_ce = 1'b1;
    wait_core(1'b0, 20);
    chk(64'({capture_done, capture_armed}), 64'h1);
    $display("test clock enable done");
    tally_and_finish();
  end
endmodule

// >>> verif/ela_host.sv
module ela_host (
  output logic jtag_tck,
  output logic jtag_sel,
  output logic jtag_capture,
  output logic jtag_shift,
  output logic jtag_update,
  output logic jtag_tdi,
  output logic en_bad,
  input wire logic jtag_tdo,
  input wire logic jtag_tdo_en
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {jtag_tck, jtag_sel, jtag_capture, jtag_shift, jtag_update, jtag_tdi, en_bad} = '0;
  end

  // One tck period, signals set well after the previous rise
  task automatic cyc(input logic s, input logic c, input logic f, input logic u, input logic d, output logic o);
    {jtag_sel, jtag_capture, jtag_shift, jtag_update, jtag_tdi} = {s, c, f, u, d};
    #15;
    o = jtag_tdo;
    if (jtag_tdo_en !== f) begin
      en_bad = 1'b1;
    end
    jtag_tck = 1'b1;
    #16;
    jtag_tck = 1'b0;
    #1;
  endtask

  // Unused serial input keeps toggling
  task automatic idle(input int n);
    logic o;
    repeat (n) cyc(1'b0, 1'b0, 1'b0, 1'b0, ~jtag_tdi, o);
  endtask

  task automatic frame(input logic [3:0] op, input logic [23:0] sel, input logic [63:0] dat,
                       output logic [91:0] cap);
    logic [91:0] sh;
    logic o;
    sh = {op, sel, dat};
    cyc(1'b1, 1'b1, 1'b0, 1'b0, ~jtag_tdi, o);
    for (int i = 0; i < 92; i++) begin
      cyc(1'b1, 1'b0, 1'b1, 1'b0, sh[i], o);
      cap[i] = o;
    end
    cyc(1'b1, 1'b0, 1'b0, 1'b1, ~jtag_tdi, o);
    idle(12);
  endtask
endmodule
